// ### rtl/tcm_channel.sv
`timescale 1ns/100ps
// One timer channel: status/control byte, 16-bit value, flag and interrupt
module tcm_channel (
	input  wire logic        ref_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        sel_i,
	input  wire logic [3:0]  reg_i,
	input  wire logic        wr_en_i,
	input  wire logic        rd_en_i,
	input  wire logic [7:0]  wr_data_i,
	input  wire logic        center_aligned_select_i,
	input  wire logic [15:0] modulo_i,
	input  wire logic [15:0] cnt_i,
	input  wire logic        step_i,
	input  wire logic        edge_i,
	output logic      [7:0]  sc_o,
	output logic      [15:0] val_o,
	output logic             irq_o
);

	typedef struct packed {
		logic        flag;
		logic        arm;
		logic        ie;
		logic        msb;
		logic        msa;
		logic [1:0]  els;
		logic [15:0] val;
	} tcm_ch_state_t;

	tcm_ch_state_t s_q;
	tcm_ch_state_t s_d;
	logic          capture;
	logic          compare;
	logic          pwm;
	logic          extreme;
	logic          event_w;

	// Mode decode; center-aligned overrides the per-channel select bits
	assign pwm     = center_aligned_select_i | s_q.msb; // RULE20
	assign capture = !center_aligned_select_i && !s_q.msb && !s_q.msa && (s_q.els != 2'h0) && edge_i; // RULE14
	// A zero value is 0% duty, a value past the modulo is 100% duty
	assign extreme = (s_q.val == tcm_pkg::VAL_RST) ||
		((modulo_i != tcm_pkg::MOD_RST) && (s_q.val > modulo_i));
	assign compare = step_i && (cnt_i == s_q.val) && (pwm || s_q.msa) &&
		!(pwm && extreme); // RULE15 RULE16
	assign event_w = capture | compare;

	// Register updates and the read-then-write-0 flag clear
	always_comb begin
		s_d = s_q;
		if (sel_i && rd_en_i && reg_i == tcm_pkg::CH_SC && s_q.flag) begin
			s_d.arm = 1'b1; // RULE18
		end
		if (sel_i && wr_en_i) begin
			unique case (reg_i)
				tcm_pkg::CH_SC: begin
					if (s_q.arm && !wr_data_i[tcm_pkg::CHF_BIT]) begin
						s_d.flag = 1'b0; // RULE18 RULE19
					end
					s_d.arm = 1'b0;
					s_d.ie  = wr_data_i[tcm_pkg::CHIE_BIT];
					s_d.msb = wr_data_i[tcm_pkg::MSB_BIT];
					s_d.msa = wr_data_i[tcm_pkg::MSA_BIT];
					s_d.els = wr_data_i[tcm_pkg::ELS_LSB +: 2];
				end
				tcm_pkg::CH_VH: s_d.val[15:8] = wr_data_i;
				tcm_pkg::CH_VL: s_d.val[7:0]  = wr_data_i;
				default: ;
			endcase
		end
		// A new event wins over a clear and restarts the sequence
		if (event_w) begin
			s_d.flag = 1'b1; // RULE14 RULE15 RULE18
			s_d.arm  = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			s_q     <= '0; // RULE19
			s_q.val <= tcm_pkg::VAL_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign sc_o  = {s_q.flag, s_q.ie, s_q.msb, s_q.msa, s_q.els, 2'h0};
	assign val_o = s_q.val;
	assign irq_o = s_q.flag & s_q.ie; // RULE17

endmodule : tcm_channel

// ### rtl/tcm_pkg.sv
package tcm_pkg;

	// Byte register map
	localparam logic [3:0] A_TSC     = 4'h0;
	localparam logic [3:0] A_CNTH    = 4'h1;
	localparam logic [3:0] A_CNTL    = 4'h2;
	localparam logic [3:0] A_MODH    = 4'h3;
	localparam logic [3:0] A_MODL    = 4'h4;
	localparam logic [3:0] A_CH_BASE = 4'h5;
	localparam logic [3:0] CH_STRIDE = 4'h3;
	localparam logic [3:0] CH_SC     = 4'h0;
	localparam logic [3:0] CH_VH     = 4'h1;
	localparam logic [3:0] CH_VL     = 4'h2;

	// Timer status/control fields
	localparam int unsigned OVF_BIT   = 7;
	localparam int unsigned OVIE_BIT  = 6;
	localparam int unsigned CENTER_ALIGNED_SELECT_BIT = 5;
	localparam int unsigned CLKS_LSB  = 3;
	localparam int unsigned PS_LSB    = 0;

	// Channel status/control fields
	localparam int unsigned CHF_BIT  = 7;
	localparam int unsigned CHIE_BIT = 6;
	localparam int unsigned MSB_BIT  = 5;
	localparam int unsigned MSA_BIT  = 4;
	localparam int unsigned ELS_LSB  = 2;

	// Codes, values after reset and counting constants
	localparam logic [1:0]  CLKS_NONE = 2'h0;
	localparam logic [15:0] CNT_RST   = 16'h0000;
	localparam logic [15:0] MOD_RST   = 16'h0000;
	localparam logic [15:0] VAL_RST   = 16'h0000;
	localparam logic [15:0] CNT_MAX   = 16'hffff;
	localparam logic [15:0] CNT_ONE   = 16'h0001;
	localparam logic [7:0]  BYTE_ZERO = 8'h00;

endpackage : tcm_pkg

// ### rtl/tcm_timer.sv
`timescale 1ns/100ps
// Contract
// RULE1 - Counter bytes read coherently via holding buffer
// RULE2 - Reset or control write unlatches counter buffer
// RULE3 - Counter byte write clears counter and coherency
// RULE4 - Debug halt freezes counter and read latches
// RULE5 - Halted control or counter write still unlatches
// RULE6 - At modulo, counter restarts at zero, flags
// RULE7 - Half-written modulo suppresses overflow flag
// RULE8 - Modulo resets zero, zero means free-running
// RULE9 - Clock disabled: modulo loads on second byte
// RULE10 - Clock running: modulo loads stepping to old
// RULE11 - Control write resets modulo write buffer state
// RULE12 - Halted modulo writes go direct, latches frozen
// RULE13 - Software clears counter before programming modulo
// RULE14 - Capture edge sets channel flag
// RULE15 - Compare match sets channel flag
// RULE16 - No flag at 0% or 100% PWM
// RULE17 - Channel interrupt when flag and enable
// RULE18 - Flag clears by read then write zero
// RULE19 - Writing one ignored; reset clears flag, enable
// RULE20 - Mode-select-B without center-aligned means edge PWM
// RULE21 - Clock select zero disables the counter
// RULE22 - Counter steps on tick when enabled, unhalted
module tcm_timer #(
	parameter int unsigned NCH = 2
) (
	input  wire logic           ref_clk_i,
	input  wire logic           sys_rst_i,
	input  wire logic [3:0]     addr_i,
	input  wire logic [7:0]     wr_data_i,
	input  wire logic           wr_en_i,
	input  wire logic           rd_en_i,
	output logic      [7:0]     rd_data_o,
	input  wire logic           count_tick_i,
	input  wire logic           debug_halt_i,
	input  wire logic [NCH-1:0] ch_edge_i,
	output logic      [1:0]     clock_source_o,
	output logic      [2:0]     prescale_o,
	output logic      [15:0]    counter_o,
	output logic                overflow_irq_o,
	output logic      [NCH-1:0] ch_irq_o
);

	typedef struct packed {
		logic [7:0]     rd_data;
		logic [15:0]    cnt;
		logic           step;
		logic [15:0]    mod;
		logic [15:0]    mod_buf;
		logic           mod_hi_w;
		logic           mod_lo_w;
		logic [15:0]    cnt_buf;
		logic           cnt_lat;
		logic           cnt_first_hi;
		logic           ovf;
		logic           ovf_arm;
		logic           ovf_ie;
		logic           center_aligned_select;
		logic [1:0]     clks;
		logic [2:0]     ps;
		logic           ovf_irq;
		logic [NCH-1:0] ch_irq;
	} tcm_state_t;

	tcm_state_t s_q;
	tcm_state_t s_d;

	logic [7:0]     ch_sc  [NCH];
	logic [15:0]    ch_val [NCH];
	logic [NCH-1:0] ch_irq_w;
	logic [NCH-1:0] ch_sel;
	logic [3:0]     ch_reg [NCH];

	logic        wr_tsc;
	logic        wr_cnt;
	logic        rd_tsc;
	logic        rd_cnth;
	logic        rd_cntl;
	logic        tick;
	logic [15:0] top;
	logic        wrap;
	logic        mod_load;
	logic        ovf_set;
	logic        halted;

	// Register strobes
	assign wr_tsc  = wr_en_i && (addr_i == tcm_pkg::A_TSC);
	assign wr_cnt  = wr_en_i && ((addr_i == tcm_pkg::A_CNTH) || (addr_i == tcm_pkg::A_CNTL));
	assign rd_tsc  = rd_en_i && (addr_i == tcm_pkg::A_TSC);
	assign rd_cnth = rd_en_i && (addr_i == tcm_pkg::A_CNTH);
	assign rd_cntl = rd_en_i && (addr_i == tcm_pkg::A_CNTL);
	assign halted  = debug_halt_i;

	// Counting tick qualified by clock select and halt
	assign tick = count_tick_i && (s_q.clks != tcm_pkg::CLKS_NONE) && !halted; // RULE21 RULE22 RULE4

	// A zero modulo behaves as the full 16-bit range
	assign top = (s_q.mod == tcm_pkg::MOD_RST) ? tcm_pkg::CNT_MAX : s_q.mod; // RULE8

	// Wrap when the counter already sits at the terminal value
	assign wrap = tick && (s_q.cnt == top); // RULE6

	// Buffered modulo takes effect on the step into the old terminal value
	assign mod_load = tick && s_q.mod_hi_w && s_q.mod_lo_w &&
		(s_q.cnt == top - tcm_pkg::CNT_ONE); // RULE10

	// Only one half written means the overflow flag is held off
	assign ovf_set = wrap && !(s_q.mod_hi_w ^ s_q.mod_lo_w); // RULE7

	// Channels, one per generate step, each at its own byte window
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		localparam logic [3:0] BASE = 4'(tcm_pkg::A_CH_BASE + i * tcm_pkg::CH_STRIDE);

		assign ch_sel[i] = (addr_i >= BASE) && (addr_i < BASE + tcm_pkg::CH_STRIDE);
		assign ch_reg[i] = addr_i - BASE;

		tcm_channel tcm_channel_i (
			.ref_clk_i (ref_clk_i),
			.sys_rst_i (sys_rst_i),
			.sel_i     (ch_sel[i]),
			.reg_i     (ch_reg[i]),
			.wr_en_i   (wr_en_i),
			.rd_en_i   (rd_en_i),
			.wr_data_i (wr_data_i),
			.center_aligned_select_i   (s_q.center_aligned_select),
			.modulo_i  (s_q.mod),
			.cnt_i     (s_q.cnt),
			.step_i    (s_q.step),
			.edge_i    (ch_edge_i[i]),
			.sc_o      (ch_sc[i]),
			.val_o     (ch_val[i]),
			.irq_o     (ch_irq_w[i])
		);
	end

	// Next-state logic for the whole timer core
	always_comb begin
		s_d         = s_q;
		s_d.step    = 1'b0;
		s_d.rd_data = tcm_pkg::BYTE_ZERO;

		// Counter: a byte write clears, otherwise step on a tick
		if (wr_cnt) begin
			s_d.cnt = tcm_pkg::CNT_RST; // RULE3
		end else if (tick) begin
			s_d.step = 1'b1;
			if (wrap) begin
				s_d.cnt = tcm_pkg::CNT_RST; // RULE6
			end else begin
				s_d.cnt = s_q.cnt + tcm_pkg::CNT_ONE; // RULE22
			end
		end

		// Overflow flag: armed by a read while set, cleared by writing 0
		if (rd_tsc && s_q.ovf) begin
			s_d.ovf_arm = 1'b1;
		end
		if (wr_tsc) begin
			if (s_q.ovf_arm && !wr_data_i[tcm_pkg::OVF_BIT]) begin
				s_d.ovf = 1'b0;
			end
			s_d.ovf_arm = 1'b0;
			s_d.ovf_ie  = wr_data_i[tcm_pkg::OVIE_BIT];
			s_d.center_aligned_select   = wr_data_i[tcm_pkg::CENTER_ALIGNED_SELECT_BIT];
			s_d.clks    = wr_data_i[tcm_pkg::CLKS_LSB +: 2];
			s_d.ps      = wr_data_i[tcm_pkg::PS_LSB +: 3];
		end
		// A fresh overflow outranks a clear in the same cycle
		if (ovf_set) begin
			s_d.ovf     = 1'b1; // RULE6
			s_d.ovf_arm = 1'b0;
		end

		// Counter read coherency; frozen while halted
		if (!halted && (rd_cnth || rd_cntl)) begin
			if (!s_q.cnt_lat) begin
				s_d.cnt_lat      = 1'b1; // RULE1
				s_d.cnt_buf      = s_q.cnt;
				s_d.cnt_first_hi = rd_cnth;
			end else if (rd_cnth != s_q.cnt_first_hi) begin
				s_d.cnt_lat = 1'b0; // RULE1
			end
		end
		// Control and counter writes unlatch even in halt
		if (wr_tsc || wr_cnt) begin
			s_d.cnt_lat = 1'b0; // RULE2 RULE3 RULE5
		end

		// Modulo writes: buffered normally, direct while halted
		if (wr_en_i && addr_i == tcm_pkg::A_MODH) begin
			if (halted) begin
				s_d.mod[15:8] = wr_data_i; // RULE12
			end else begin
				s_d.mod_buf[15:8] = wr_data_i;
				s_d.mod_hi_w      = 1'b1;
			end
		end
		if (wr_en_i && addr_i == tcm_pkg::A_MODL) begin
			if (halted) begin
				s_d.mod[7:0] = wr_data_i; // RULE12
			end else begin
				s_d.mod_buf[7:0] = wr_data_i;
				s_d.mod_lo_w     = 1'b1;
			end
		end
		// With no clock selected the pair lands at once
		if (s_d.mod_hi_w && s_d.mod_lo_w && s_q.clks == tcm_pkg::CLKS_NONE) begin
			s_d.mod      = s_d.mod_buf; // RULE9
			s_d.mod_hi_w = 1'b0;
			s_d.mod_lo_w = 1'b0;
		end else if (mod_load) begin
			s_d.mod      = s_q.mod_buf; // RULE10
			s_d.mod_hi_w = 1'b0;
			s_d.mod_lo_w = 1'b0;
		end
		if (wr_tsc) begin
			s_d.mod_hi_w = 1'b0; // RULE11
			s_d.mod_lo_w = 1'b0;
		end

		// Read data for the next cycle; unmapped addresses read zero
		if (rd_en_i) begin
			unique case (addr_i)
				tcm_pkg::A_TSC:  s_d.rd_data = {s_q.ovf, s_q.ovf_ie, s_q.center_aligned_select,
					s_q.clks, s_q.ps};
				tcm_pkg::A_CNTH: s_d.rd_data = s_q.cnt_lat ? s_q.cnt_buf[15:8] : s_q.cnt[15:8];
				tcm_pkg::A_CNTL: s_d.rd_data = s_q.cnt_lat ? s_q.cnt_buf[7:0] : s_q.cnt[7:0];
				tcm_pkg::A_MODH: s_d.rd_data = s_q.mod[15:8];
				tcm_pkg::A_MODL: s_d.rd_data = s_q.mod[7:0];
				default: begin
					for (int k = 0; k < NCH; k++) begin
						if (ch_sel[k]) begin
							unique case (ch_reg[k])
								tcm_pkg::CH_SC: s_d.rd_data = ch_sc[k];
								tcm_pkg::CH_VH: s_d.rd_data = ch_val[k][15:8];
								tcm_pkg::CH_VL: s_d.rd_data = ch_val[k][7:0];
								default: ;
							endcase
						end
					end
				end
			endcase
		end

		// Interrupt requests are registered so outputs come from flops
		s_d.ovf_irq = s_d.ovf & s_d.ovf_ie;
		s_d.ch_irq  = ch_irq_w; // RULE17
	end

	// State register; reset clears counter, modulo and all controls
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			s_q     <= '0; // RULE2 RULE19
			s_q.cnt <= tcm_pkg::CNT_RST; // RULE3
			s_q.mod <= tcm_pkg::MOD_RST; // RULE8
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data_o      = s_q.rd_data;
	assign clock_source_o = s_q.clks;
	assign prescale_o     = s_q.ps;
	assign counter_o      = s_q.cnt;
	assign overflow_irq_o = s_q.ovf_irq;
	assign ch_irq_o       = s_q.ch_irq;

endmodule : tcm_timer

// ### tb/tcm_timer_bench.sv
`timescale 1ns/100ps
// Map: 0 ctrl, 1/2 counter, 3/4 modulo, 5-7 channel 0, 8-a channel 1
module tcm_timer_bench;
	logic        clk, rst, we, re, tick, halt;
	logic [3:0]  addr;
	logic [7:0]  wd;
	logic [1:0]  edg;
	logic [7:0]  rdat;
	logic [1:0]  cks, chirq;
	logic [2:0]  ps;
	logic [15:0] cnt;
	logic        ovf;
	int          bad_count, checked;

	tcm_timer #(.NCH(2)) tcm_timer_i (.ref_clk_i(clk), .sys_rst_i(rst), .addr_i(addr),
		.wr_data_i(wd), .wr_en_i(we), .rd_en_i(re), .rd_data_o(rdat), .count_tick_i(tick),
		.debug_halt_i(halt), .ch_edge_i(edg), .clock_source_o(cks), .prescale_o(ps),
		.counter_o(cnt), .overflow_irq_o(ovf), .ch_irq_o(chirq));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd   <= d;
		we   <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
		// Step off the edge so registered outputs have settled
		#1;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		re   <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 chk("rd_data_o", {8'h00, e}, {8'h00, rdat});
	endtask : rd

	task automatic tk(input int n);
		repeat (n) begin
			@(posedge clk);
			tick <= 1'b1;
		end
		@(posedge clk);
		tick <= 1'b0;
		// Counter updates at this edge; look at it only once settled
		#1;
	endtask : tk

	task automatic report_and_stop;
		if (bad_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	// Main sequence; every wait is a fixed cycle count
	initial begin
		{rst, we, re, tick, halt} = 5'h10;
		{addr, wd, edg} = 14'h0000;
		bad_count = 0;
		checked = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(4'h3, 8'h00);
		rd(4'h4, 8'h00);
		rd(4'h5, 8'h00);
		rd(4'hf, 8'h00);
		tk(3);
		chk("counter_o", 16'h0000, cnt);
		wr(4'h3, 8'h00);
		wr(4'h4, 8'h05);
		rd(4'h4, 8'h05);
		wr(4'h0, 8'h48);
		chk("clock_source_o", 16'h0001, cks);
		tk(5);
		chk("counter_o", 16'h0005, cnt);
		tk(1);
		chk("counter_o", 16'h0000, cnt);
		rd(4'h0, 8'hc8);
		chk("overflow_irq_o", 16'h0001, ovf);
		wr(4'h0, 8'h48);
		// Coherent counter reads and unlatching
		tk(2);
		rd(4'h1, 8'h00);
		tk(1);
		rd(4'h2, 8'h02);
		rd(4'h2, 8'h03);
		tk(1);
		wr(4'h0, 8'h48);
		rd(4'h2, 8'h04);
		wr(4'h1, 8'h5a);
		rd(4'h2, 8'h00);
		rd(4'h1, 8'h00);
		// Halt freezes counter and latch, control write still unlatches
		tk(2);
		rd(4'h1, 8'h00);
		tk(1);
		@(posedge clk) halt <= 1'b1;
		tk(2);
		chk("counter_o", 16'h0003, cnt);
		rd(4'h2, 8'h02);
		rd(4'h2, 8'h02);
		wr(4'h0, 8'h48);
		rd(4'h2, 8'h03);
		@(posedge clk) halt <= 1'b0;
		// Half-written modulo: no flag; full pair loads at old top
		wr(4'h3, 8'h00);
		tk(3);
		rd(4'h0, 8'h48);
		wr(4'h4, 8'h08);
		rd(4'h4, 8'h05);
		tk(5);
		rd(4'h4, 8'h08);
		tk(4);
		chk("counter_o", 16'h0000, cnt);
		rd(4'h0, 8'hc8);
		wr(4'h0, 8'h48);
		@(posedge clk) halt <= 1'b1;
		wr(4'h3, 8'h00);
		wr(4'h4, 8'h03);
		rd(4'h4, 8'h03);
		@(posedge clk) halt <= 1'b0;
		wr(4'h3, 8'h00);
		wr(4'h0, 8'h48);
		wr(4'h4, 8'h06);
		tk(4);
		chk("counter_o", 16'h0000, cnt);
		// Channel 0 compare, flag clear sequence
		wr(4'h1, 8'h00);
		wr(4'h5, 8'h50);
		wr(4'h6, 8'h00);
		wr(4'h7, 8'h02);
		tk(2);
		rd(4'h5, 8'hd0);
		chk("ch_irq_o", 16'h0001, chirq);
		wr(4'h5, 8'hd0);
		rd(4'h5, 8'hd0);
		wr(4'h5, 8'h50);
		rd(4'h5, 8'h50);
		chk("ch_irq_o", 16'h0000, chirq);
		// Channel 1 capture edge
		wr(4'h8, 8'h44);
		@(posedge clk) edg <= 2'b10;
		@(posedge clk) edg <= 2'b00;
		rd(4'h8, 8'hc4);
		chk("ch_irq_o", 16'h0002, chirq);
		// Edge PWM: 0% duty never flags, normal duty does
		wr(4'h5, 8'h28);
		wr(4'h7, 8'h00);
		tk(6);
		rd(4'h5, 8'h28);
		wr(4'h1, 8'h00);
		wr(4'h7, 8'h01);
		tk(1);
		rd(4'h5, 8'ha8);
		// Center-aligned: channel compares with its own select bits clear
		wr(4'h0, 8'h6d);
		chk("prescale_o", 16'h0005, ps);
		chk("clock_source_o", 16'h0001, cks);
		wr(4'h5, 8'h08);
		rd(4'h5, 8'h08);
		wr(4'h1, 8'h00);
		tk(1);
		rd(4'h5, 8'h88);
		report_and_stop();
	end
endmodule : tcm_timer_bench

// ### tb/tcm_timer_props.sv
`timescale 1ns/100ps
// Port-level checks on counter, clock select and reset behaviour
module tcm_timer_props #(
	parameter int unsigned NCH = 2
) (
	input wire logic           ref_clk_i,
	input wire logic           sys_rst_i,
	input wire logic [3:0]     addr_i,
	input wire logic [7:0]     wr_data_i,
	input wire logic           wr_en_i,
	input wire logic           rd_en_i,
	input wire logic [7:0]     rd_data_o,
	input wire logic           count_tick_i,
	input wire logic           debug_halt_i,
	input wire logic [NCH-1:0] ch_edge_i,
	input wire logic [1:0]     clock_source_o,
	input wire logic [2:0]     prescale_o,
	input wire logic [15:0]    counter_o,
	input wire logic           overflow_irq_o,
	input wire logic [NCH-1:0] ch_irq_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	// Counter byte write, and a tick that is allowed to count
	logic cw;
	logic run;
	assign cw  = wr_en_i && (addr_i == 4'h1 || addr_i == 4'h2);
	assign run = count_tick_i && clock_source_o != 2'h0 && !debug_halt_i;

	a_cnt_clear: assert property (cw |=> counter_o == 16'h0000)
		else $error("counter not cleared by counter write");
	a_halt_freeze: assert property (debug_halt_i && !cw |=> $stable(counter_o))
		else $error("counter moved during halt");
	a_off_hold: assert property (clock_source_o == 2'h0 && !cw |=> $stable(counter_o))
		else $error("counter moved with no clock source");
	a_idle_hold: assert property (!count_tick_i && !cw |=> $stable(counter_o))
		else $error("counter moved without tick");
	a_step_up: assert property (run && !cw
		|=> counter_o == $past(counter_o) + 16'h0001 || counter_o == 16'h0000)
		else $error("counter step wrong");
	a_free_wrap: assert property (run && !cw && counter_o == 16'hffff
		|=> counter_o == 16'h0000)
		else $error("counter did not wrap at top");
	a_rst_clear: assert property ($fell(sys_rst_i)
		|-> counter_o == 16'h0000 && ch_irq_o == '0 && !overflow_irq_o)
		else $error("state not cleared by reset");
	a_clks_load: assert property (wr_en_i && addr_i == 4'h0
		|=> clock_source_o == $past(wr_data_i[4:3]))
		else $error("clock select not loaded");

	c_cnt_write: cover property (cw);
	c_halt_tick: cover property (debug_halt_i && count_tick_i);
	c_ch_irq: cover property (|ch_irq_o);
endmodule : tcm_timer_props

bind tcm_timer tcm_timer_props #(.NCH(NCH)) tcm_timer_props_i (.ref_clk_i, .sys_rst_i,
	.addr_i, .wr_data_i, .wr_en_i, .rd_en_i, .rd_data_o, .count_tick_i, .debug_halt_i,
	.ch_edge_i, .clock_source_o, .prescale_o, .counter_o, .overflow_irq_o, .ch_irq_o);
